/* File: design/tec_timer_regs.vh */
`ifndef TEC_TIMER_REGS_VH
`define TEC_TIMER_REGS_VH
// Register byte addresses
`define TEC_ADDR_COUNT 6'h00
`define TEC_ADDR_CCA 6'h04
`define TEC_ADDR_CCB 6'h08
`define TEC_ADDR_MODE 6'h0C
`define TEC_ADDR_CCCTL 6'h10
`define TEC_ADDR_PRESC 6'h14
// Word addresses (byte address bits [5:2])
`define TEC_W_COUNT 4'h0
`define TEC_W_CCA 4'h1
`define TEC_W_CCB 4'h2
`define TEC_W_MODE 4'h3
`define TEC_W_CCCTL 4'h4
`define TEC_W_PRESC 4'h5
// Mode control fields
`define TEC_MODE_OVF_BIT 0
`define TEC_MODE_SEL_LO 2
`define TEC_MODE_SEL_HI 3
`define TEC_MODE_STOP 2'h0
`define TEC_MODE_FREERUN 2'h1
`define TEC_MODE_EDGECLR 2'h2
`define TEC_MODE_MATCHCLR 2'h3
// Capture/compare control fields
`define TEC_CC_A_CAPTURE_BIT 0
`define TEC_CC_A_TRIG_BIT 1
`define TEC_CC_B_CAPTURE_BIT 2
// Prescaler fields
`define TEC_PR_CLK_LO 0
`define TEC_PR_CLK_HI 1
`define TEC_PR_ESP_LO 4
`define TEC_PR_ESP_HI 5
`define TEC_PR_ESS_LO 6
`define TEC_PR_ESS_HI 7
`define TEC_CLK_DIV4 2'h0
`define TEC_CLK_DIV16 2'h1
`define TEC_CLK_DIV512 2'h2
`define TEC_CLK_EDGE 2'h3
// Edge select codes
`define TEC_ES_FALL 2'h0
`define TEC_ES_RISE 2'h1
`define TEC_ES_NONE 2'h2
`define TEC_ES_BOTH 2'h3
// Divider terminal counts
`define TEC_DIV4_LAST 9'h003
`define TEC_DIV16_LAST 9'h00F
`define TEC_DIV512_LAST 9'h1FF
`endif

/* File: design/tec_timer.v */
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "tec_timer_regs.vh"
// Function
// - Mode 10 counts up, primary edge clears
// - Edge-clear mode starts without waiting edge
// - Primary edge clears counter, counting resumes
// - No edge: counter wraps and continues
// - Compare match raises that register's interrupt
// - Capture A on secondary or opposite primary
// - Edge-clear: primary edge captures B, clears
// - Edge clock select in edge-clear holds zero
// - Opposite-phase capture A gives no interrupt
// - Then secondary edge interrupts, no capture
// - Compare match leaves counter unchanged outside mode 11
// - Capture A trigger selectable primary/secondary
// - Capture B triggered only by primary input
// - Counter read returns current count
// - Mode 01 free-runs, no external clear
// - Wrap after all-ones sets overflow flag
// - Free-run supports all register pairings
// - Free-run compare A interrupts every match
// - Free-run capture B on primary edge
// - Both capture, secondary only: no B capture
module tec_timer #(
  parameter WIDTH = 16
) (
  input wire i_core_clk,
  input wire i_reset_n,
  input wire i_clk_en,
  input wire [5:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  input wire i_primary_edge_input,
  input wire i_secondary_edge_input,
  output reg o_interrupt_a,
  output reg o_interrupt_b
);

  reg [WIDTH-1:0] count_q;
  reg [WIDTH-1:0] cca_q;
  reg [WIDTH-1:0] ccb_q;
  reg [1:0] mode_q;
  reg ovf_q;
  reg [2:0] ccctl_q;
  reg [7:0] presc_q;
  reg [8:0] div_q;
  reg [2:0] pri_sync_q;
  reg [2:0] sec_sync_q;
  reg pri_lvl_q;
  reg sec_lvl_q;
  reg ack_q;

  // Edge qualification against a select code
  function edge_hit;
    input [1:0] sel;
    input rise;
    input fall;
    begin
      case (sel)
        `TEC_ES_FALL: edge_hit = fall;
        `TEC_ES_RISE: edge_hit = rise;
        `TEC_ES_BOTH: edge_hit = rise | fall;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // Byte-lane merge of a write into the low 16 bits
  function [31:0] merge16;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      merge16 = old;
      merge16[7:0] = be[0] ? wd[7:0] : old[7:0];
      merge16[15:8] = be[1] ? wd[15:8] : old[15:8];
    end
  endfunction

  // Zero-extend a counter-wide value to the bus width
  function [31:0] zext;
    input [WIDTH-1:0] v;
    begin
      zext = 32'h0000_0000;
      zext[WIDTH-1:0] = v;
    end
  endfunction

  wire [1:0] clk_sel = presc_q[`TEC_PR_CLK_HI:`TEC_PR_CLK_LO];
  wire [1:0] es_pri = presc_q[`TEC_PR_ESP_HI:`TEC_PR_ESP_LO];
  wire [1:0] es_sec = presc_q[`TEC_PR_ESS_HI:`TEC_PR_ESS_LO];
  wire cap_a = ccctl_q[`TEC_CC_A_CAPTURE_BIT];
  wire trig_a_pri = ccctl_q[`TEC_CC_A_TRIG_BIT];
  wire cap_b = ccctl_q[`TEC_CC_B_CAPTURE_BIT];

  // Change counts once second and third stages agree
  wire pri_agree = (pri_sync_q[2] == pri_sync_q[1]);
  wire sec_agree = (sec_sync_q[2] == sec_sync_q[1]);
  wire pri_rise = pri_agree & pri_sync_q[2] & ~pri_lvl_q;
  wire pri_fall = pri_agree & ~pri_sync_q[2] & pri_lvl_q;
  wire sec_rise = sec_agree & sec_sync_q[2] & ~sec_lvl_q;
  wire sec_fall = sec_agree & ~sec_sync_q[2] & sec_lvl_q;

  wire pri_valid = edge_hit(es_pri, pri_rise, pri_fall);
  wire pri_opp = edge_hit(es_pri, pri_fall, pri_rise);
  wire sec_valid = edge_hit(es_sec, sec_rise, sec_fall);

  wire running = (mode_q != `TEC_MODE_STOP);
  wire edge_clr_mode = (mode_q == `TEC_MODE_EDGECLR);

  reg [8:0] div_last;
  always @* begin
    case (clk_sel)
      `TEC_CLK_DIV4: div_last = `TEC_DIV4_LAST;
      `TEC_CLK_DIV16: div_last = `TEC_DIV16_LAST;
      default: div_last = `TEC_DIV512_LAST;
    endcase
  end

  wire div_tick = running & (div_q == div_last);
  wire count_tick = (clk_sel == `TEC_CLK_EDGE) ?
                    (running & pri_valid) : div_tick;

  // Register access
  wire [3:0] widx = i_avs_address[5:2];
  wire wr = i_avs_write & ~ack_q & i_clk_en;
  wire wr_count = wr & (widx == `TEC_W_COUNT);
  wire wr_cca = wr & (widx == `TEC_W_CCA);
  wire wr_ccb = wr & (widx == `TEC_W_CCB);
  wire wr_mode = wr & (widx == `TEC_W_MODE);
  wire wr_ccctl = wr & (widx == `TEC_W_CCCTL);
  wire wr_presc = wr & (widx == `TEC_W_PRESC);

  // One wait state: answer on the second edge
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;

  // Capture and compare events
  // capture A trigger choice
  wire a_trig_sec = cap_a & sec_valid;
  wire a_trig_opp = cap_a & trig_a_pri & pri_opp;
  wire a_capture = trig_a_pri ? a_trig_opp : a_trig_sec;
  wire a_cap_irq = trig_a_pri ? (cap_a & sec_valid) : a_trig_sec;
  // B triggered by the primary input only
  wire b_capture = cap_b & running & pri_valid;
  wire a_match = ~cap_a & running & (count_q == cca_q);
  wire b_match = ~cap_b & running & (count_q == ccb_q);
  wire [WIDTH-1:0] all_ones = {WIDTH{1'b1}};
  wire wrap = count_tick & (count_q == all_ones);

  reg match_a_seen_q;
  reg match_b_seen_q;
  wire [31:0] cca_wr = merge16(zext(cca_q), i_avs_writedata,
                               i_avs_byteenable);
  wire [31:0] ccb_wr = merge16(zext(ccb_q), i_avs_writedata,
                               i_avs_byteenable);

  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pri_sync_q <= 3'h0;
      sec_sync_q <= 3'h0;
      pri_lvl_q <= 1'b0;
      sec_lvl_q <= 1'b0;
    end else if (i_clk_en) begin
      pri_sync_q <= {pri_sync_q[1:0], i_primary_edge_input};
      sec_sync_q <= {sec_sync_q[1:0], i_secondary_edge_input};
      if (pri_agree) begin
        pri_lvl_q <= pri_sync_q[2];
      end
      if (sec_agree) begin
        sec_lvl_q <= sec_sync_q[2];
      end
    end
  end

  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_q <= 9'h000;
    end else if (i_clk_en) begin
      if (!running || div_tick) begin
        div_q <= 9'h000;
      end else begin
        div_q <= div_q + 9'h001;
      end
    end
  end

  // Counter
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_q <= {WIDTH{1'b0}};
    end else if (i_clk_en) begin
      if (!running) begin
        count_q <= {WIDTH{1'b0}};
      // edge clock in edge-clear holds zero
      end else if (edge_clr_mode && clk_sel == `TEC_CLK_EDGE) begin
        count_q <= {WIDTH{1'b0}};
      // clear follows the capture into B
      end else if (edge_clr_mode && pri_valid) begin
        count_q <= {WIDTH{1'b0}};
      end else if (mode_q == `TEC_MODE_MATCHCLR && ~cap_a &&
                   count_q == cca_q && count_tick) begin
        count_q <= {WIDTH{1'b0}};
      // count up on each count clock
      // wraps past maximum and keeps going
      // matches do not touch the counter outside mode 11
      end else if (count_tick) begin
        count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // Capture/compare registers
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cca_q <= {WIDTH{1'b0}};
      ccb_q <= {WIDTH{1'b0}};
    end else if (i_clk_en) begin
      if (running && a_capture) begin
        cca_q <= count_q;
      end else if (wr_cca) begin
        cca_q <= cca_wr[WIDTH-1:0];
      end
      if (b_capture) begin
        ccb_q <= count_q;
      end else if (wr_ccb) begin
        ccb_q <= ccb_wr[WIDTH-1:0];
      end
    end
  end

  // Control registers
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q <= `TEC_MODE_STOP;
      ovf_q <= 1'b0;
      ccctl_q <= 3'h0;
      presc_q <= 8'h00;
    end else if (i_clk_en) begin
      if (wr_mode && i_avs_byteenable[0]) begin
        mode_q <= i_avs_writedata[`TEC_MODE_SEL_HI:`TEC_MODE_SEL_LO];
      end
      // wrap sets overflow; set beats clear
      // flag held until software writes zero
      if (wrap) begin
        ovf_q <= 1'b1;
      end else if (wr_mode && i_avs_byteenable[0]) begin
        ovf_q <= i_avs_writedata[`TEC_MODE_OVF_BIT];
      end
      // each register picks compare or capture
      if (wr_ccctl && i_avs_byteenable[0]) begin
        ccctl_q <= i_avs_writedata[2:0];
      end
      if (wr_presc && i_avs_byteenable[0]) begin
        presc_q <= i_avs_writedata[7:0];
      end
    end
  end

  // Interrupt pulses, match fires once per entry
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_interrupt_a <= 1'b0;
      o_interrupt_b <= 1'b0;
      match_a_seen_q <= 1'b0;
      match_b_seen_q <= 1'b0;
    end else if (i_clk_en) begin
      match_a_seen_q <= a_match;
      match_b_seen_q <= b_match;
      // every new match on A interrupts
      o_interrupt_a <= (a_match & ~match_a_seen_q) | (running & a_cap_irq);
      o_interrupt_b <= (b_match & ~match_b_seen_q) | b_capture;
    end else begin
      o_interrupt_a <= 1'b0;
      o_interrupt_b <= 1'b0;
    end
  end

  // Read path
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_q <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_clk_en) begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
      if (i_avs_read && !ack_q) begin
        case (widx)
          `TEC_W_COUNT: o_avs_readdata <= zext(count_q);
          `TEC_W_CCA: o_avs_readdata <= zext(cca_q);
          `TEC_W_CCB: o_avs_readdata <= zext(ccb_q);
          `TEC_W_MODE: o_avs_readdata <= {28'h0000000, mode_q, 1'b0, ovf_q};
          `TEC_W_CCCTL: o_avs_readdata <= {29'h00000000, ccctl_q};
          `TEC_W_PRESC: o_avs_readdata <= {24'h000000, presc_q};
          default: o_avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

/* File: tb/tec_timer_props.sv */
`timescale 1ns/1ps
module tec_timer_props (
  input wire i_core_clk,
  input wire i_reset_n,
  input wire i_clk_en,
  input wire [5:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire o_interrupt_a,
  input wire o_interrupt_b
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  wire req = i_avs_read | i_avs_write;
  pulse_a_a: assert property (o_interrupt_a |=> !o_interrupt_a)
    else $error("irq a wider than one cycle");
  pulse_b_a: assert property (o_interrupt_b |=> !o_interrupt_b)
    else $error("irq b wider than one cycle");
  en_quiet_a: assert property (!i_clk_en [*2] |-> !o_interrupt_a && !o_interrupt_b)
    else $error("irq while clock enable low");
  wait_first_a: assert property (req && !$past(req) |-> o_avs_waitrequest)
    else $error("no wait state on new access");
  wait_one_a: assert property (req && o_avs_waitrequest && i_clk_en |=> !o_avs_waitrequest)
    else $error("access not answered");
  rd_hold_a: assert property (!i_avs_read |=> $stable(o_avs_readdata))
    else $error("read data moved without read");
  rd_upper_a: assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  rd_unmap_a: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address[5:2] > 4'h5 |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind tec_timer tec_timer_props i_props (.i_core_clk(i_core_clk),
  .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_interrupt_a(o_interrupt_a), .o_interrupt_b(o_interrupt_b));

/* File: tb/tec_edge_src.sv */
`timescale 1ns/1ps
module tec_edge_src (
  input wire i_core_clk,
  input wire i_slow,
  input wire i_pri,
  input wire i_sec,
  output logic o_pri,
  output logic o_sec
);
  logic [3:0] cnt_q = 4'h0;
  initial o_pri = 1'b0;
  initial o_sec = 1'b0;
  // Pin levels follow after a short or long settle
  always @(posedge i_core_clk) begin
    if ({i_pri, i_sec} == {o_pri, o_sec}) begin
      cnt_q <= 4'h0;
    end else if (cnt_q >= (i_slow ? 4'h8 : 4'h0)) begin
      o_pri <= i_pri;
      o_sec <= i_sec;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

/* File: tb/test_tec_timer.sv */
`timescale 1ns/1ps
module test_tec_timer;
  localparam W = 8;
  logic clk = 0, rst_n = 0, en = 1, rd = 0, wr = 0, slow = 0;
  logic pri_q = 0, sec_q = 0, pri, sec, irq_a, irq_b, waitreq;
  logic [5:0] adr = 6'h00;
  logic [31:0] wd = 32'h0, rdata, rv, v1, seed = 32'd40;
  logic [31:0] exp_q[$];
  int error_cnt = 0, checked = 0, cnt_a = 0, cnt_b = 0;
  initial forever #2 clk = ~clk;
  tec_timer #(.WIDTH(W)) i_dut (.i_core_clk(clk), .i_reset_n(rst_n),
    .i_clk_en(en), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_primary_edge_input(pri),
    .i_secondary_edge_input(sec), .o_interrupt_a(irq_a),
    .o_interrupt_b(irq_b));
  tec_edge_src i_src (.i_core_clk(clk), .i_slow(slow), .i_pri(pri_q),
    .i_sec(sec_q), .o_pri(pri), .o_sec(sec));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        error_cnt++;
        stop_test();
      end
    end while (waitreq !== 1'b0);
    v = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wrr(input logic [5:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rv);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0, rv);
  endtask
  task automatic wait_ovf();
    rv = 32'h0;
    for (int n = 0; n < 600 && rv[0] !== 1'b1; n++) xfer(1'b0, 6'h0C, 0, rv);
    chk(rv[0], 1'b1);
  endtask
  task automatic pins(input logic p, input logic s);
    slow <= xs() & 1;
    pri_q <= p;
    sec_q <= s;
    repeat (30) @(posedge clk);
  endtask
  always @(negedge clk) begin
    if (irq_a === 1'b1) cnt_a++;
    if (irq_b === 1'b1) cnt_b++;
    if (rd && waitreq === 1'b0 && exp_q.size() > 0)
      chk(rdata, exp_q.pop_front());
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(6'h00, 0);
    rdc(6'h18, 0);
    v1 = xs() & ((1 << W) - 1);
    wrr(6'h04, v1);
    rdc(6'h04, v1);
    wrr(6'h14, 32'h90);
    wrr(6'h10, 32'h0);
    wrr(6'h04, 32'h80);
    wrr(6'h08, 32'h40);
    wrr(6'h0C, 32'h04);
    cnt_a = 0;
    cnt_b = 0;
    en <= 1'b0;
    repeat (5) @(posedge clk);
    en <= 1'b1;
    wait_ovf();
    chk(cnt_a, 1);
    chk(cnt_b, 1);
    wrr(6'h0C, 32'h04);
    rdc(6'h0C, 32'h04);
    wait_ovf();
    chk(cnt_a, 2);
    wrr(6'h0C, 32'h0);
    wrr(6'h14, 32'h50);
    wrr(6'h10, 32'h07);
    wrr(6'h0C, 32'h08);
    cnt_a = 0;
    cnt_b = 0;
    xfer(1'b0, 6'h00, 0, v1);
    repeat (40) @(posedge clk);
    xfer(1'b0, 6'h00, 0, rv);
    chk(rv > v1, 1);
    v1 = rv;
    pins(1'b1, 1'b0);
    chk(cnt_b, 1);
    xfer(1'b0, 6'h00, 0, rv);
    chk(rv < 10, 1);
    xfer(1'b0, 6'h08, 0, rv);
    chk(rv >= v1, 1);
    pins(1'b0, 1'b0);
    chk(cnt_a, 0);
    xfer(1'b0, 6'h04, 0, v1);
    chk(v1 > 3 && v1 < 17, 1);
    pins(1'b0, 1'b1);
    chk(cnt_a, 1);
    rdc(6'h04, v1);
    wrr(6'h14, 32'h53);
    repeat (20) @(posedge clk);
    rdc(6'h00, 0);
    wrr(6'h0C, 32'h0);
    wrr(6'h10, 32'h05);
    wrr(6'h14, 32'h60);
    xfer(1'b0, 6'h08, 0, v1);
    wrr(6'h0C, 32'h04);
    pins(1'b0, 1'b0);
    cnt_a = 0;
    cnt_b = 0;
    pins(1'b1, 1'b1);
    chk(cnt_a, 1);
    chk(cnt_b, 0);
    rdc(6'h08, v1);
    stop_test();
  end
endmodule
